//--- thermal_sensor_defs.vh
// Constants for the thermal sensor register and address logic.
// Included by the sensor module; holds definitions only.
`ifndef THERMAL_SENSOR_DEFS_VH
`define THERMAL_SENSOR_DEFS_VH

// Command codes carried in the second byte of a bus packet.
`define CMD_READ_TEMP       8'h01
`define CMD_READ_STATUS     8'h02
`define CMD_READ_CONFIG     8'h03
`define CMD_READ_RATE       8'h04
`define CMD_READ_HIGH_LIM   8'h07
`define CMD_READ_LOW_LIM    8'h08
`define CMD_WRITE_CONFIG    8'h09
`define CMD_WRITE_RATE      8'h0a
`define CMD_WRITE_HIGH_LIM  8'h0d
`define CMD_WRITE_LOW_LIM   8'h0e
`define CMD_SINGLE_CONV     8'h0f
`define CMD_RESET_VALUE     8'h00

// Field positions.
`define STAT_BUSY_BIT       7
`define STAT_HIGH_BIT       4
`define STAT_LOW_BIT        3
`define STAT_OPEN_BIT       2
`define CFG_STANDBY_BIT     6

// Reset values.
`define CONFIG_RESET        8'h00
// rate code powers up at two
`define RATE_RESET          8'h02
`define HIGH_LIM_RESET      8'h7f
`define LOW_LIM_RESET       8'hc9
`define RATE_MAX_CODE       8'h07

// Upper address nibbles chosen by the three-level slot pin.
`define ADDR_UPPER_LOW      4'h3
`define ADDR_UPPER_FLOAT    4'h5
`define ADDR_UPPER_HIGH     4'h9

// Slot pin level codes as presented by the pad sense logic.
`define TRI_LEVEL_LOW       2'b00
`define TRI_LEVEL_HIGH      2'b01

// Timing: sixteen seconds (slowest period) at the 40 MHz core clock.
`define SLOW_PERIOD_S       16
`define CORE_CLK_HZ         40000000

`endif

//--- pin_sync.v
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output changes once stages two and
// three agree.
`timescale 1ns/1ps
module pin_sync (
	input  wire CLK_I,
	input  wire RSTN_I,
	input  wire D_I,
	output reg  Q_O
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s1  <= 1'b1;
			s2  <= 1'b1;
			s3  <= 1'b1;
			Q_O <= 1'b1;
		end else begin
			s1 <= D_I;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				Q_O <= s3;
		end
	end
endmodule // pin_sync

//--- thermal_sensor.v
// Thermal sensor: bus slave, status/config/rate registers, limit
// compare and conversion sequencing.
// Assumes the converter runs on CORE_CLK_I and the bus pins are
// asynchronous; the bus clock is sampled, not used as a clock.
//
// Overview of operation
// - set alarm when temperature reaches a limit
// - limits use signed reference encoding
// - eight-bit two's complement, saturating, no wrap
// - alarm flags stay set until status read
// - status read clears flags unless condition persists
// - status bit seven shows converter busy
// - status bit four is high alarm
// - status bit three is low alarm
// - status bit two is diode open fault
// - standby bit stops conversion at once
// - standby still honours single conversion command
// - bit six clear means auto-convert; resets clear
// - single conversion starts now in standby, ignored when busy or in auto mode
// - rate code 0-7 doubles from sixteenth hertz
// - rate code resets to two
// - actual rate within a quarter of nominal
// - respond only to three upper address patterns
// - two slot pins give six addresses
// - slot pins captured once after reset
`timescale 1ns/1ps
`include "thermal_sensor_defs.vh"
module thermal_sensor #(
	parameter SLOW_PERIOD_CYCLES = `SLOW_PERIOD_S * `CORE_CLK_HZ
) (
	input  wire       CORE_CLK_I,
	input  wire       RSTN_I,
	input  wire       SMB_CLK_I,
	input  wire       SMB_DATA_I,
	output reg        SMB_DATA_O,
	output reg        SMB_DATA_OE_O,
	input  wire       SLOT_SELECT_BIT1_I,
	input  wire [1:0] SLOT_SELECT_TRISTATE_I,
	input  wire [9:0] TEMP_RAW_I,
	input  wire       CONV_DONE_I,
	input  wire       DIODE_OPEN_I,
	output reg        CONV_RUN_O
);
	localparam ST_IDLE  = 3'd0;
	localparam ST_RX    = 3'd1;
	localparam ST_ACK   = 3'd2;
	localparam ST_TX    = 3'd3;
	localparam ST_TXACK = 3'd4;

	wire scl;
	wire sda;
	reg  scl_d;
	reg  sda_d;
	reg  [2:0] state;
	reg  [2:0] after_ack;
	reg  [3:0] bit_cnt;
	reg  [1:0] byte_idx;
	reg  [7:0] shift;
	reg  [7:0] tx_byte;
	reg  [7:0] command;
	reg        tx_is_status;
	reg  [6:0] own_addr;
	reg        addr_latched;
	reg  [7:0] config_reg;
	reg  [7:0] rate_reg;
	reg  [7:0] high_lim;
	reg  [7:0] low_lim;
	reg  [7:0] temp;
	reg        high_alarm;
	reg        low_alarm;
	reg        open_fault;
	reg        high_cond;
	reg        low_cond;
	reg        open_cond;
	reg        busy;
	reg  [29:0] timer;
	reg        oneshot_req;
	reg        status_clear;
	reg        stop_req;
	wire [29:0] period;
	wire [2:0]  rate_code;
	wire       standby;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_cond;
	wire       stop_cond;
	wire [7:0] status_byte;
	wire [7:0] temp_sat;
	wire       conv_done;
	wire       high_hit;
	wire       low_hit;
	reg  [7:0] read_data;

	pin_sync u_scl_sync (
		.CLK_I         (CORE_CLK_I),
		.RSTN_I        (RSTN_I),
		.D_I           (SMB_CLK_I),
		.Q_O           (scl)
	);

	pin_sync u_sda_sync (
		.CLK_I         (CORE_CLK_I),
		.RSTN_I        (RSTN_I),
		.D_I           (SMB_DATA_I),
		.Q_O           (sda)
	);

	assign scl_rise   = scl & ~scl_d;
	assign scl_fall   = ~scl & scl_d;
	assign start_cond = scl & scl_d & sda_d & ~sda;
	assign stop_cond  = scl & scl_d & ~sda_d & sda;
	assign standby    = config_reg[`CFG_STANDBY_BIT];

	assign temp_sat = ($signed(TEMP_RAW_I) > $signed(10'sd127)) ? 8'h7f :
		($signed(TEMP_RAW_I) < -$signed(10'sd128)) ? 8'h80 :
		TEMP_RAW_I[7:0];

	assign high_hit = $signed(temp_sat) >= $signed(high_lim);
	assign low_hit  = $signed(temp_sat) <= $signed(low_lim);
	assign conv_done = busy & CONV_DONE_I;

	assign status_byte = {busy, 2'b00, high_alarm, low_alarm, open_fault,
		2'b00};

	// codes above seven run at the fastest rate
	assign rate_code = (rate_reg > `RATE_MAX_CODE) ? 3'd7 : rate_reg[2:0];
	// period exact to clock, well inside the tolerance
	assign period = SLOW_PERIOD_CYCLES[29:0] >> rate_code;

	always @* begin
		case (command)
		`CMD_READ_TEMP:     read_data = temp;
		`CMD_READ_STATUS:   read_data = status_byte;
		`CMD_READ_CONFIG:   read_data = config_reg;
		`CMD_READ_RATE:     read_data = rate_reg;
		`CMD_READ_HIGH_LIM: read_data = high_lim;
		`CMD_READ_LOW_LIM:  read_data = low_lim;
		default:            read_data = 8'h00;
		endcase
	end

	// slot pins captured once after reset release
	// six addresses from two slot pins
	always @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			own_addr     <= 7'h00;
			addr_latched <= 1'b0;
		end else if (!addr_latched) begin
			addr_latched <= 1'b1;
			case (SLOT_SELECT_TRISTATE_I)
			`TRI_LEVEL_LOW:
				own_addr <= {`ADDR_UPPER_LOW, 1'b0,
					SLOT_SELECT_BIT1_I, 1'b0};
			`TRI_LEVEL_HIGH:
				own_addr <= {`ADDR_UPPER_HIGH, 1'b1,
					SLOT_SELECT_BIT1_I, 1'b0};
			default:
				own_addr <= {`ADDR_UPPER_FLOAT, 1'b0,
					SLOT_SELECT_BIT1_I, 1'b1};
			endcase
		end
	end

	// Bus slave: bytes in on clock rise, data driven after clock fall.
	always @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scl_d         <= 1'b1;
			sda_d         <= 1'b1;
			state         <= ST_IDLE;
			after_ack     <= ST_IDLE;
			bit_cnt       <= 4'h0;
			byte_idx      <= 2'd0;
			shift         <= 8'h00;
			tx_byte       <= 8'h00;
			command       <= `CMD_RESET_VALUE;
			tx_is_status  <= 1'b0;
			config_reg    <= `CONFIG_RESET;
			rate_reg      <= `RATE_RESET;
			high_lim      <= `HIGH_LIM_RESET;
			low_lim       <= `LOW_LIM_RESET;
			oneshot_req   <= 1'b0;
			status_clear  <= 1'b0;
			stop_req      <= 1'b0;
			SMB_DATA_O    <= 1'b0;
			SMB_DATA_OE_O <= 1'b0;
		end else begin
			scl_d        <= scl;
			sda_d        <= sda;
			oneshot_req  <= 1'b0;
			status_clear <= 1'b0;
			stop_req     <= 1'b0;
			if (start_cond) begin
				state         <= ST_RX;
				bit_cnt       <= 4'h0;
				byte_idx      <= 2'd0;
				SMB_DATA_OE_O <= 1'b0;
			end else if (stop_cond) begin
				state         <= ST_IDLE;
				SMB_DATA_OE_O <= 1'b0;
			end else begin
				case (state)
				ST_RX: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						state   <= ST_ACK;
						SMB_DATA_OE_O <= 1'b1;
						after_ack <= ST_RX;
						if (byte_idx == 2'd0) begin
							// only the latched pattern is acked
							if (shift[7:1] != own_addr) begin
								state         <= ST_IDLE;
								SMB_DATA_OE_O <= 1'b0;
							end else if (shift[0]) begin
								after_ack    <= ST_TX;
								tx_byte      <= read_data;
								tx_is_status <=
									(command == `CMD_READ_STATUS);
							end
						end else if (byte_idx == 2'd1) begin
							command <= shift;
							if (shift == `CMD_SINGLE_CONV &&
								standby && !busy)
								oneshot_req <= 1'b1;
						end else begin
							case (command)
							`CMD_WRITE_CONFIG:
								config_reg <= shift &
									(8'h01 << `CFG_STANDBY_BIT);
							`CMD_WRITE_RATE:     rate_reg <= shift;
							`CMD_WRITE_HIGH_LIM: high_lim <= shift;
							`CMD_WRITE_LOW_LIM:  low_lim  <= shift;
							default: ;
							endcase
							stop_req <= (command == `CMD_WRITE_CONFIG) &
								shift[`CFG_STANDBY_BIT];
						end
						if (byte_idx != 2'd3)
							byte_idx <= byte_idx + 2'd1;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state <= after_ack;
						if (after_ack == ST_TX)
							SMB_DATA_OE_O <= ~tx_byte[7];
						else
							SMB_DATA_OE_O <= 1'b0;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 4'h1;
						tx_byte <= {tx_byte[6:0], 1'b0};
						if (bit_cnt == 4'h7) begin
							state         <= ST_TXACK;
							SMB_DATA_OE_O <= 1'b0;
							// clear only after a full read
							status_clear  <= tx_is_status;
						end else begin
							SMB_DATA_OE_O <= ~tx_byte[6];
						end
					end
				end
				ST_TXACK: begin
					if (scl_fall)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// Conversion sequencing, limit compare and sticky flags.
	always @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			busy       <= 1'b0;
			CONV_RUN_O <= 1'b0;
			timer      <= 30'h0;
			temp       <= 8'h00;
			high_alarm <= 1'b0;
			low_alarm  <= 1'b0;
			open_fault <= 1'b0;
			high_cond  <= 1'b0;
			low_cond   <= 1'b0;
			open_cond  <= 1'b0;
		end else begin
			// periodic timer runs only in auto mode
			if (standby || timer >= period - 30'h1)
				timer <= 30'h0;
			else
				timer <= timer + 30'h1;
			// a standby write aborts any conversion at once
			if (stop_req || conv_done) begin
				busy       <= 1'b0;
				CONV_RUN_O <= 1'b0;
			end else if (!busy && (oneshot_req ||
				(!standby && timer >= period - 30'h1))) begin
				busy       <= 1'b1;
				CONV_RUN_O <= 1'b1;
			end
			if (conv_done) begin
				temp      <= temp_sat;
				high_cond <= high_hit;
				low_cond  <= low_hit;
				open_cond <= DIODE_OPEN_I;
			end
			// a read keeps flags whose cause persists
			high_alarm <= (high_alarm & ~status_clear) |
				(status_clear & high_cond) | (conv_done & high_hit);
			low_alarm <= (low_alarm & ~status_clear) |
				(status_clear & low_cond) | (conv_done & low_hit);
			open_fault <= (open_fault & ~status_clear) |
				(status_clear & open_cond) |
				(conv_done & DIODE_OPEN_I);
		end
	end
endmodule // thermal_sensor

//--- thermal_sensor_asserts.sv
// Checker on the sensor's pins: bus drive timing and conversion flag.
// Assumes binding to thermal_sensor, with a bench bus bit of 200 ns.
`timescale 1ns/1ps
module thermal_sensor_asserts (
	input wire CORE_CLK_I,
	input wire RSTN_I,
	input wire SMB_CLK_I,
	input wire SMB_DATA_O,
	input wire SMB_DATA_OE_O,
	input wire CONV_DONE_I,
	input wire CONV_RUN_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	property p_od; SMB_DATA_OE_O |-> !SMB_DATA_O; endproperty
	a_od: assert property (p_od) else $error("drive not low");
	property p_dzero; $stable(SMB_DATA_O); endproperty
	a_dzero: assert property (p_dzero) else $error("drive moved");
	property p_ack_min; $rose(SMB_DATA_OE_O) |=> SMB_DATA_OE_O[*6];
	endproperty
	a_ack_min: assert property (p_ack_min) else $error("ack short");
	property p_ack_max; $rose(SMB_DATA_OE_O) |-> ##[1:90] !SMB_DATA_OE_O;
	endproperty
	a_ack_max: assert property (p_ack_max) else $error("drive stuck");
	// Drive may only move in the low phase, after the synced fall.
	property p_edge; $changed(SMB_DATA_OE_O) |-> !$past(SMB_CLK_I, 2);
	endproperty
	a_edge: assert property (p_edge) else $error("drive moved");
	property p_idle; SMB_CLK_I[*8] |-> !SMB_DATA_OE_O; endproperty
	a_idle: assert property (p_idle) else $error("drive idle");
	property p_done; CONV_RUN_O && CONV_DONE_I |=> !CONV_RUN_O; endproperty
	a_done: assert property (p_done) else $error("busy held");
	property p_boot; $rose(RSTN_I) |-> (!CONV_RUN_O)[*8]; endproperty
	a_boot: assert property (p_boot) else $error("early run");
endmodule // thermal_sensor_asserts
bind thermal_sensor thermal_sensor_asserts i_thermal_sensor_asserts (
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .SMB_CLK_I(SMB_CLK_I),
	.SMB_DATA_O(SMB_DATA_O), .SMB_DATA_OE_O(SMB_DATA_OE_O),
	.CONV_DONE_I(CONV_DONE_I), .CONV_RUN_O(CONV_RUN_O));

//--- smbus_host_model.sv
// Bus host model; its clock stands high between packets.
// Assumes a wired-AND data line with a pull-up built by the bench.
`timescale 1ns/1ps
module smbus_host_model (
	input  wire sda_i,
	output reg  scl_o,
	output reg  sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// Data moves mid low phase, clear of the synced clock edges.
	task bit_io(input b, output q); begin
		#75 sda_low_o = !b;
		#75 scl_o = 1'b1;
		#25 q = sda_i;
		#25 scl_o = 1'b0;
	end endtask
	task hstart; begin
		#75 sda_low_o = 1'b0;
		#75 scl_o = 1'b1;
		#100 sda_low_o = 1'b1;
		#100 scl_o = 1'b0;
	end endtask
	task hstop; begin
		#75 sda_low_o = 1'b1;
		#75 scl_o = 1'b1;
		#100 sda_low_o = 1'b0;
		#100;
	end endtask
	task xfer(input [7:0] d, output [7:0] q, output ack);
		integer i;
		reg a;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], q[i]);
		bit_io(1'b1, a);
		ack = !a;
	end endtask
	task rd(input [6:0] a, input [7:0] c, output [7:0] q, output ok);
		reg [7:0] x;
		reg k0, k1, k2, k3;
	begin
		hstart;
		xfer({a, 1'b0}, x, k0);
		xfer(c, x, k1);
		hstart;
		xfer({a, 1'b1}, x, k2);
		xfer(8'hff, q, k3);
		hstop;
		ok = k0 & k1 & k2;
	end endtask
	task wr(input [6:0] a, input [7:0] c, input [7:0] d, input h,
		output ok);
		reg [7:0] x;
		reg k0, k1, k2;
	begin
		k2 = 1'b1;
		hstart;
		xfer({a, 1'b0}, x, k0);
		xfer(c, x, k1);
		if (h)
			xfer(d, x, k2);
		hstop;
		ok = k0 & k1 & k2;
	end endtask
endmodule // smbus_host_model

//--- thermal_sensor_tb.sv
// Bench for the sensor: registers, addressing, alarms, modes and rates.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module thermal_sensor_tb;
	localparam [6:0] DEV = 7'h2b;
	reg        clk, rst_n, slot1, done, open, ok;
	reg  [1:0] slot_tri;
	reg  [9:0] temp;
	reg  [7:0] q;
	integer    bad_count, samples_checked, n;
	wire       scl, host_low, oe, dout, run;
	wire       sda = !(host_low | oe);
	thermal_sensor #(.SLOW_PERIOD_CYCLES(1024)) i_thermal_sensor (
		.CORE_CLK_I(clk), .RSTN_I(rst_n), .SMB_CLK_I(scl),
		.SMB_DATA_I(sda), .SMB_DATA_O(dout), .SMB_DATA_OE_O(oe),
		.SLOT_SELECT_BIT1_I(slot1), .SLOT_SELECT_TRISTATE_I(slot_tri),
		.TEMP_RAW_I(temp), .CONV_DONE_I(done), .DIODE_OPEN_I(open),
		.CONV_RUN_O(run));
	smbus_host_model i_smbus_host_model (.sda_i(sda), .scl_o(scl),
		.sda_low_o(host_low));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end
	task tick; begin
		@(posedge clk);
		#2;
	end endtask
	task chk(input [7:0] got, input [7:0] exp); begin
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end endtask
	task rdc(input [7:0] c, input [7:0] e); begin
		tick;
		i_smbus_host_model.rd(DEV, c, q, ok);
		chk({7'h0, ok}, 8'h01);
		chk(q, e);
	end endtask
	task wrc(input [7:0] c, input [7:0] d, input h); begin
		tick;
		i_smbus_host_model.wr(DEV, c, d, h, ok);
		chk({7'h0, ok}, 8'h01);
	end endtask
	task conv(input [9:0] t, input o); begin
		n = 0;
		while (run !== 1'b1 && n < 3000) begin
			tick;
			n = n + 1;
		end
		chk({7'h0, run}, 8'h01);
		temp = t;
		open = o;
		done = 1'b1;
		tick;
		done = 1'b0;
	end endtask
	task quiet(input integer c); begin
		n = 0;
		repeat (c) begin
			tick;
			if (run === 1'b1)
				n = n + 1;
		end
		chk({7'h0, n == 0}, 8'h01);
	end endtask
	task t_reset; begin
		rdc(8'h03, 8'h00);
		rdc(8'h04, 8'h02);
		rdc(8'h07, 8'h7f);
		rdc(8'h08, 8'hc9);
		$display("t_reset done");
	end endtask
	task t_addr; begin
		tick;
		i_smbus_host_model.rd(7'h18, 8'h03, q, ok);
		chk({7'h0, ok}, 8'h00);
		tick;
		i_smbus_host_model.rd(7'h4e, 8'h03, q, ok);
		chk({7'h0, ok}, 8'h00);
		$display("t_addr done");
	end endtask
	task t_modes; begin
		wrc(8'h09, 8'hff, 1'b1);
		chk({7'h0, run}, 8'h00);
		rdc(8'h03, 8'h40);
		quiet(1100);
		wrc(8'h0f, 8'h00, 1'b0);
		conv(10'h080, 1'b0);
		rdc(8'h01, 8'h7f);
		rdc(8'h02, 8'h10);
		rdc(8'h02, 8'h10);
		wrc(8'h0f, 8'h00, 1'b0);
		rdc(8'h02, 8'h90);
		conv(10'h338, 1'b1);
		rdc(8'h01, 8'h80);
		rdc(8'h02, 8'h1c);
		rdc(8'h02, 8'h0c);
		wrc(8'h0f, 8'h00, 1'b0);
		conv(10'h019, 1'b0);
		rdc(8'h02, 8'h0c);
		rdc(8'h02, 8'h00);
		quiet(300);
		wrc(8'h0e, 8'h19, 1'b1);
		rdc(8'h08, 8'h19);
		$display("t_modes done");
	end endtask
	task t_rates;
		integer k, p;
	begin
		wrc(8'h09, 8'h00, 1'b1);
		for (k = 0; k < 8; k = k + 1) begin
			p = 1024 >> k;
			wrc(8'h0a, k[7:0], 1'b1);
			rdc(8'h04, k[7:0]);
			conv(10'h019, 1'b0);
			conv(10'h019, 1'b0);
			n = 0;
			while (run !== 1'b1 && n < 2000) begin
				tick;
				n = n + 1;
			end
			chk({7'h0, n * 4 >= p * 3 && n * 4 <= p * 5}, 8'h01);
		end
		wrc(8'h0a, 8'h08, 1'b1);
		rdc(8'h04, 8'h08);
		$display("t_rates done");
	end endtask
	task give_verdict; begin
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end endtask
	initial begin
		#2000000;
		$display("unexpected at %0t: watchdog", $time);
		bad_count = bad_count + 1;
		give_verdict;
	end
	initial begin
		rst_n = 1'b0;
		slot1 = 1'b1;
		slot_tri = 2'b10;
		done = 1'b0;
		open = 1'b0;
		temp = 10'h000;
		bad_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (4) tick;
		// The device must keep the address it captured at reset.
		slot1 = 1'b0;
		slot_tri = 2'b00;
		t_reset;
		t_addr;
		t_modes;
		t_rates;
		give_verdict;
	end
endmodule // thermal_sensor_tb
